// ### hw/sscs_params.svh
`ifndef SSCS_PARAMS_SVH
`define SSCS_PARAMS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define SSCS_DATA_W 8
`define SSCS_ADDR_W 8
`define SSCS_CNT_W 3
`define SSCS_TOP_BIT 7

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SSCS_OFF_DATA 8'h00
`define SSCS_OFF_STATUS 8'h04
`define SSCS_OFF_CLEAR 8'h08
`define SSCS_OFF_MODE 8'h0c
`define SSCS_OFF_CTRL 8'h10
`define SSCS_OFF_RUN 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define SSCS_ST_OVF 0
`define SSCS_ST_BFF 1
`define SSCS_ST_BUSY 2
`define SSCS_CLR_OVF 0
`define SSCS_MODE_IRQSRC 0
`define SSCS_CTRL_DAP 0
`define SSCS_CTRL_CKP 1
`define SSCS_CTRL_LSB 2
`define SSCS_CTRL_LEN7 3
`define SSCS_CTRL_TXEN 4
`define SSCS_RUN_START 0
`define SSCS_RUN_STOP 1

// ----------------------------------------
// word length, counts, reset values
// ----------------------------------------
`define SSCS_LAST_BIT8 3'h7
`define SSCS_LAST_BIT7 3'h6
`define SSCS_FIRST_BIT 3'h0
`define SSCS_CNT_STEP 3'h1
`define SSCS_OUT_IDLE 1'h1
`define SSCS_SCK_IDLE 1'h1
`define SSCS_MODE_RST 1'h0
`define SSCS_SYNC_RST 2'h3

`endif

// ### hw/sscs_pkg.sv
`include "sscs_params.svh"

package sscs_pkg;

    typedef enum logic {
        PH_IDLE,
        PH_WORD
    } sscs_phase_e;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } sscs_sync_s;

    typedef struct packed {
        logic prev;
    } sscs_edge_s;

    typedef struct packed {
        logic enabled;
        logic ovf;
        logic rx_full;
        logic tx_pend;
        logic irq_src;
        logic dap;
        logic ckp;
        logic lsb;
        logic len7;
        logic txen;
        logic [`SSCS_DATA_W-1:0] tx_buf;
        logic [`SSCS_DATA_W-1:0] rx_buf;
        logic [`SSCS_DATA_W-1:0] tx_sh;
        logic [`SSCS_DATA_W-1:0] rx_sh;
        logic [`SSCS_DATA_W-1:0] rdata;
        logic [`SSCS_CNT_W-1:0] cnt;
        sscs_phase_e phase;
        logic out;
        logic irq;
    } sscs_main_s;

endpackage : sscs_pkg

// ### hw/sscs_sync.sv
`timescale 1ns/10ps
`include "sscs_params.svh"

// two-stage synchroniser for the serial clock and serial input data pins
module sscs_sync
    import sscs_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [1:0] i_async,
    output logic [1:0] o_sync
);

    sscs_sync_s r;
    sscs_sync_s n;

    always_comb begin
        n = r;
        n.s1 = i_async;
        n.s2 = r.s1;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= '{s1: `SSCS_SYNC_RST, s2: `SSCS_SYNC_RST};
        end else begin
            r <= n;
        end
    end

    assign o_sync = r.s2;

endmodule : sscs_sync

// ### hw/sscs_edge.sv
`timescale 1ns/10ps
`include "sscs_params.svh"

// finds leading and trailing edges of the phase-corrected serial clock
module sscs_edge
    import sscs_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_sck,
    input wire logic i_invert,
    output logic o_lead,
    output logic o_trail
);

    sscs_edge_s r;
    sscs_edge_s n;
    logic eff;

    assign eff = i_sck ^ i_invert; // RQ7

    always_comb begin
        n = r;
        n.prev = eff;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= '{prev: `SSCS_SCK_IDLE};
        end else begin
            r <= n;
        end
    end

    // idle level high: leading edge falls, trailing edge rises
    assign o_lead = r.prev & ~eff;
    assign o_trail = ~r.prev & eff;

    a_edge_exclusive: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ7
        o_lead |-> !o_trail ##1 (r.prev == (i_sck ^ i_invert)) || $changed(i_invert))
        else $error("lead and trail edge seen together");

endmodule : sscs_edge

// ### hw/sscs_slave.sv
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "sscs_params.svh"

// Behaviour
// RQ1 - receive-only needs transfer-end interrupt source
// RQ2 - overrun is the only reported error
// RQ3 - seven or eight bit words, either order
// RQ4 - serial clock sampled, at most one sixth
// RQ5 - data phase zero captures at clock start; the code captures phase zero on the trailing edge
// RQ6 - data phase also sets output timing
// RQ7 - clock phase bit inverts serial clock
// RQ8 - duplex: transfer-end or buffer-empty interrupt
// RQ9 - shifting only on master clock edges
// RQ10 - software loads transmit word before clocking
// RQ11 - word end raises interrupt, data readable
// RQ12 - write while full replaces pending word
// RQ13 - continuous mid-word read returns transmit word
// RQ14 - source select changeable before last bit
// RQ15 - software reads then writes each interrupt
// RQ16 - software switches source for final word
// RQ17 - software masks interrupt then stops channel
// RQ18 - software reinitialises after clock enable change
// RQ19 - data read clears buffer-full flag
// RQ20 - writing one clears the overrun flag
// RQ21 - unread word overwritten sets overrun flag
// RQ22 - seven-bit words use low seven bits
module sscs_slave
    import sscs_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [`SSCS_ADDR_W-1:0] i_addr,
    input wire logic [`SSCS_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`SSCS_DATA_W-1:0] o_rdata,
    input wire logic i_slave_clock_pin,
    input wire logic i_serial_in_pin,
    output logic o_serial_out_pin,
    output logic o_transfer_irq
);

    localparam sscs_main_s MAIN_RST = '{
        phase: PH_IDLE,
        out: `SSCS_OUT_IDLE,
        irq_src: `SSCS_MODE_RST,
        default: '0
    };

    sscs_main_s r;
    sscs_main_s n;

    // ----------------------------------------
    // decoding helpers
    // ----------------------------------------
    function automatic logic hit(input logic [`SSCS_ADDR_W-1:0] addr, input logic [`SSCS_ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction : hit

    // bit position of the count-th bit on the wire
    function automatic logic [`SSCS_CNT_W-1:0] bit_idx(
        input logic [`SSCS_CNT_W-1:0] cnt,
        input logic lsb,
        input logic len7
    );
        logic [`SSCS_CNT_W-1:0] last;
        last = len7 ? `SSCS_LAST_BIT7 : `SSCS_LAST_BIT8;
        bit_idx = lsb ? cnt : last - cnt;
    endfunction : bit_idx

    // ----------------------------------------
    // pin sampling and edge detection
    // ----------------------------------------
    logic sck_s;
    logic si_s;
    logic lead;
    logic trail;

    sscs_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_async({i_slave_clock_pin, i_serial_in_pin}), // RQ4
        .o_sync({sck_s, si_s})
    );

    sscs_edge u_edge (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_sck(sck_s),
        .i_invert(r.ckp),
        .o_lead(lead),
        .o_trail(trail)
    );

    // ----------------------------------------
    // event terms
    // ----------------------------------------
    logic [`SSCS_CNT_W-1:0] last_bit;
    logic [`SSCS_CNT_W-1:0] cur_idx;
    logic sample_ev;
    logic drive_ev;
    logic word_done;
    logic wr_data;
    logic rd_data;
    logic cont_hold;
    logic rd_take;
    logic run_wr;
    logic stop_req;
    logic clr_ovf;
    logic load;
    logic first_bit;

    assign last_bit = r.len7 ? `SSCS_LAST_BIT7 : `SSCS_LAST_BIT8; // RQ3
    assign cur_idx = bit_idx(r.cnt, r.lsb, r.len7); // RQ3
    // phase 1 captures on the leading edge, half a clock early
    assign sample_ev = r.enabled & (r.dap ? lead : trail); // RQ5
    assign drive_ev = r.enabled & (r.dap ? trail : lead); // RQ6
    assign word_done = sample_ev & (r.cnt == last_bit); // RQ3
    assign wr_data = i_wr & hit(i_addr, `SSCS_OFF_DATA);
    assign rd_data = i_rd & hit(i_addr, `SSCS_OFF_DATA);
    // mid-word read in continuous mode shows the queued transmit word
    assign cont_hold = r.irq_src & (r.phase == PH_WORD) & r.tx_pend; // RQ13
    assign rd_take = rd_data & ~cont_hold; // RQ19
    assign run_wr = i_wr & hit(i_addr, `SSCS_OFF_RUN);
    assign stop_req = run_wr & i_wdata[`SSCS_RUN_STOP];
    assign clr_ovf = i_wr & hit(i_addr, `SSCS_OFF_CLEAR) & i_wdata[`SSCS_CLR_OVF]; // RQ20
    // queued word moves into the shifter between words only
    assign load = r.enabled & r.txen & r.tx_pend & ~stop_req
        & (((r.phase == PH_IDLE) & ~drive_ev & ~sample_ev) | word_done); // RQ10
    assign first_bit = r.tx_buf[bit_idx(`SSCS_FIRST_BIT, r.lsb, r.len7)];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [`SSCS_DATA_W-1:0] stat;
        stat = '0;
        n = r;
        n.irq = 1'b0;
        n.rdata = '0;

        // register reads and flag clears come first so that sets win
        if (i_rd) begin
            case (i_addr)
                `SSCS_OFF_DATA: begin
                    if (cont_hold) begin
                        n.rdata = r.tx_buf; // RQ13
                    end else begin
                        n.rdata = r.rx_buf; // RQ11
                        n.rx_full = 1'b0; // RQ19
                    end
                end
                `SSCS_OFF_STATUS: begin
                    stat[`SSCS_ST_OVF] = r.ovf; // RQ2
                    stat[`SSCS_ST_BFF] = r.rx_full | r.tx_pend;
                    stat[`SSCS_ST_BUSY] = (r.phase == PH_WORD);
                    n.rdata = stat;
                end
                `SSCS_OFF_MODE: begin
                    n.rdata[`SSCS_MODE_IRQSRC] = r.irq_src;
                end
                `SSCS_OFF_CTRL: begin
                    n.rdata[`SSCS_CTRL_DAP] = r.dap;
                    n.rdata[`SSCS_CTRL_CKP] = r.ckp;
                    n.rdata[`SSCS_CTRL_LSB] = r.lsb;
                    n.rdata[`SSCS_CTRL_LEN7] = r.len7;
                    n.rdata[`SSCS_CTRL_TXEN] = r.txen;
                end
                `SSCS_OFF_RUN: begin
                    n.rdata[`SSCS_RUN_START] = r.enabled;
                end
                default: begin
                    n.rdata = '0;
                end
            endcase
        end
        if (clr_ovf) begin
            n.ovf = 1'b0; // RQ20
        end

        // output side: present the current bit on the drive edge
        if (drive_ev) begin
            if (r.txen) begin
                n.out = r.tx_sh[cur_idx]; // RQ6
            end
            if (!r.dap) begin
                n.phase = PH_WORD; // RQ9
            end
        end

        // input side: capture on the sample edge
        if (sample_ev) begin
            n.rx_sh[cur_idx] = si_s; // RQ5
            if (word_done) begin
                if (r.rx_full & ~rd_take) begin
                    n.ovf = 1'b1; // RQ21
                end
                n.rx_buf = n.rx_sh; // RQ22
                n.rx_full = 1'b1; // RQ11
                n.rx_sh = '0;
                n.cnt = '0;
                n.phase = PH_IDLE;
                n.irq = ~r.irq_src; // RQ14
            end else begin
                n.cnt = r.cnt + `SSCS_CNT_STEP; // RQ9
                n.phase = PH_WORD;
            end
        end

        // queued transmit word enters the shifter
        if (load) begin
            n.tx_sh = r.tx_buf;
            n.tx_pend = 1'b0;
            // armed word counts as in progress so a later write waits for it
            n.phase = PH_WORD; // RQ13
            if (r.irq_src) begin
                n.irq = 1'b1; // RQ8
            end
            if (r.dap) begin
                n.out = first_bit; // RQ6
            end
        end

        // register writes
        if (i_wr) begin
            case (i_addr)
                `SSCS_OFF_DATA: begin
                    n.tx_buf = i_wdata; // RQ12
                    n.tx_pend = 1'b1;
                end
                `SSCS_OFF_MODE: begin
                    n.irq_src = i_wdata[`SSCS_MODE_IRQSRC]; // RQ14
                end
                `SSCS_OFF_CTRL: begin
                    if (!r.enabled) begin
                        n.dap = i_wdata[`SSCS_CTRL_DAP];
                        n.ckp = i_wdata[`SSCS_CTRL_CKP];
                        n.lsb = i_wdata[`SSCS_CTRL_LSB];
                        n.len7 = i_wdata[`SSCS_CTRL_LEN7];
                        n.txen = i_wdata[`SSCS_CTRL_TXEN];
                    end
                end
                `SSCS_OFF_RUN: begin
                    if (i_wdata[`SSCS_RUN_START] & ~r.enabled) begin
                        n.enabled = 1'b1;
                        n.cnt = '0;
                        n.phase = PH_IDLE;
                        n.rx_sh = '0;
                    end
                    if (i_wdata[`SSCS_RUN_STOP]) begin
                        n.enabled = 1'b0;
                        n.cnt = '0;
                        n.phase = PH_IDLE;
                        n.rx_sh = '0;
                        n.irq = 1'b0;
                    end
                end
                default: begin
                    n.enabled = n.enabled;
                end
            endcase
        end

        // receive-only or stopped channel parks the output high
        if (!n.txen | !n.enabled) begin
            n.out = `SSCS_OUT_IDLE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= MAIN_RST;
        end else begin
            r <= n;
        end
    end

    assign o_rdata = r.rdata;
    assign o_serial_out_pin = r.out;
    assign o_transfer_irq = r.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);

    sequence s_word_end;
        word_done && !stop_req;
    endsequence

    sequence s_single_end;
        s_word_end ##0 !r.irq_src;
    endsequence

    sequence s_preload;
        load && r.dap && !i_wr;
    endsequence

    a_transfer_end_irq: assert property (s_single_end |=> o_transfer_irq && r.rx_full) // RQ11
        else $error("single word end without interrupt or data");

    a_buffer_empty_irq: assert property (load && r.irq_src && !stop_req |=> o_transfer_irq) // RQ8
        else $error("buffer empty interrupt missing");

    a_no_end_irq_cont: assert property (s_word_end ##0 r.irq_src && !load |=> !o_transfer_irq) // RQ14
        else $error("transfer end interrupt in buffer empty mode");

    a_overrun_set: assert property (s_word_end ##0 (r.rx_full && !rd_take) |=> r.ovf) // RQ21
        else $error("unread word overwritten without overrun");

    a_overrun_clear: assert property (clr_ovf && !(word_done && r.rx_full) |=> !r.ovf) // RQ20
        else $error("overrun flag not cleared");

    a_read_clears_bff: assert property (rd_take && !word_done |=> !r.rx_full && o_rdata == $past(r.rx_buf)) // RQ19
        else $error("data read left buffer full");

    a_cont_read_keep: assert property (rd_data && cont_hold && !word_done // RQ13
        |=> o_rdata == $past(r.tx_buf) && r.rx_full == $past(r.rx_full))
        else $error("mid-word read disturbed the transfer");

    a_tx_overwrite: assert property (wr_data |=> r.tx_pend && r.tx_buf == $past(i_wdata)) // RQ12
        else $error("transmit write not taken");

    a_idle_no_shift: assert property (!lead && !trail && !run_wr |=> $stable(r.cnt)) // RQ9
        else $error("bit count moved without a serial clock edge");

    a_len7_top: assert property (s_word_end ##0 r.len7 |=> r.rx_buf[`SSCS_TOP_BIT] == 1'b0) // RQ22
        else $error("seven-bit word set the top bit");

    a_early_output: assert property (s_preload ##0 r.txen |=> o_serial_out_pin == $past(first_bit)) // RQ6
        else $error("first bit not presented before the clock");

    a_word_length: assert property (sample_ev && !word_done && !run_wr |=> r.cnt != `SSCS_FIRST_BIT) // RQ3
        else $error("word ended early");

    a_rx_only_quiet: assert property (!r.txen |=> o_serial_out_pin == `SSCS_OUT_IDLE) // RQ8
        else $error("output moved in receive-only mode");

    a_rdata_only_read: assert property (!i_rd |=> o_rdata == '0)
        else $error("read data outside a read answer");

endmodule : sscs_slave

// ### sim/sscs_master_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// serial master driving clock and data
// ----------------------------------------
module sscs_master_model (
    input wire logic i_miso,
    output logic o_sck,
    output logic o_mosi
);
    localparam int HALF_NS = 80;

    initial begin
        o_sck = 1'h1;
        o_mosi = 1'h0;
    end

    // clock rests at its idle level between frames
    task automatic park(input logic ckp);
        o_sck = !ckp;
    endtask : park

    task automatic xfer(input logic [7:0] tx_w, input int nbits, input logic ckp, input logic dap,
            input logic lsb, output logic [7:0] rx_w);
        int idx;
        rx_w = 8'h00;
        #3.3;
        for (int i = 0; i < nbits; i++) begin
            idx = lsb ? i : nbits - 1 - i;
            o_mosi = tx_w[idx];
            if (dap) #(HALF_NS);
            o_sck = ckp;
            if (dap) rx_w[idx] = i_miso;
            #(HALF_NS);
            o_sck = !ckp;
            if (!dap) rx_w[idx] = i_miso;
            if (!dap) #(HALF_NS);
        end
        #(HALF_NS);
        // released data line shows no stale bit
        o_mosi = !o_mosi;
    endtask : xfer
endmodule : sscs_master_model

// ### sim/sscs_slave_bench.sv
`timescale 1ns/10ps
`include "sscs_params.svh"

module sscs_slave_bench;
    logic clk;
    logic arst_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rdata;
    logic sck;
    logic mosi;
    logic miso;
    logic irq;
    logic [7:0] w0, w1, w2, m0, m1, sw, mw;
    logic [7:0] exp_rx[$];
    int fails = 0;
    int checks_done = 0;
    int irq_cnt = 0;
    int irq_exp = 0;
    int cyc = 0;
    int seed = 32'hd474;

    initial begin
        clk = 1'h0;
        forever #5 clk = !clk;
    end

    sscs_slave u_sscs_slave (.i_clk_sys(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(rdata), .i_slave_clock_pin(sck),
        .i_serial_in_pin(mosi), .o_serial_out_pin(miso), .o_transfer_irq(irq));

    sscs_master_model u_sscs_master_model (.i_miso(miso), .o_sck(sck), .o_mosi(mosi));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
        checks_done++;
        if (got !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, e, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        @(posedge clk);
        wr_stb <= 1'h0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge clk);
        rd_stb <= 1'h0;
        #1;
        chk(what, e, rdata);
    endtask : rd_chk

    task automatic wait_irq();
        irq_exp++;
        for (int n = 0; n < 400 && irq_cnt < irq_exp; n++) @(posedge clk);
        repeat (3) @(posedge clk);
        chk("irq count", irq_exp[7:0], irq_cnt[7:0]);
    endtask : wait_irq

    task automatic setup(input logic [3:0] cfg, input logic txen, input logic src);
        wr(`SSCS_OFF_RUN, 8'h02);
        wr(`SSCS_OFF_CTRL, {3'h0, txen, cfg});
        wr(`SSCS_OFF_MODE, {7'h0, src});
        u_sscs_master_model.park(cfg[1]);
        repeat (6) @(posedge clk);
        wr(`SSCS_OFF_RUN, 8'h01);
    endtask : setup

    // one word each way; model word masked to the word length
    task automatic frame(input logic [7:0] mwd, input logic [7:0] swd, input logic [3:0] cfg);
        logic [7:0] got;
        exp_rx.push_back(cfg[3] ? {1'h0, mwd[6:0]} : mwd);
        u_sscs_master_model.xfer(mwd, cfg[3] ? 7 : 8, cfg[1], cfg[0], cfg[2], got);
        chk("serial out word", cfg[3] ? {1'h0, swd[6:0]} : swd, got);
    endtask : frame

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'h1) begin
            irq_cnt <= irq_cnt + 1;
        end
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        arst_n = 1'h0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'h0;
        rd_stb = 1'h0;
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        #1;
        chk("out idle", 8'h01, {7'h0, miso});
        rd_chk(`SSCS_OFF_STATUS, 8'h00, "status reset");
        rd_chk(`SSCS_OFF_MODE, 8'h00, "mode reset");
        rd_chk(`SSCS_OFF_RUN, 8'h00, "run reset");
        wr(8'h18, 8'hff);
        rd_chk(8'h18, 8'h00, "unmapped");
        $display("test reset done");

        for (int c = 0; c < 16; c++) begin
            setup(c[3:0], 1'h1, 1'h0);
            sw = 8'($random(seed));
            mw = 8'($random(seed));
            wr(`SSCS_OFF_DATA, sw);
            frame(mw, sw, c[3:0]);
            wait_irq();
            rd_chk(`SSCS_OFF_DATA, exp_rx.pop_front(), "rx word");
        end
        $display("test duplex single done");

        setup(4'h9, 1'h0, 1'h0);
        repeat (100) @(posedge clk);
        chk("irq without clock", irq_exp[7:0], irq_cnt[7:0]);
        frame(8'($random(seed)), 8'hff, 4'h9);
        wait_irq();
        frame(8'($random(seed)), 8'hff, 4'h9);
        wait_irq();
        rd_chk(`SSCS_OFF_STATUS, 8'h03, "status overrun");
        void'(exp_rx.pop_front());
        rd_chk(`SSCS_OFF_DATA, exp_rx.pop_front(), "newest rx word");
        rd_chk(`SSCS_OFF_STATUS, 8'h01, "status after read");
        wr(`SSCS_OFF_CLEAR, 8'h01);
        rd_chk(`SSCS_OFF_STATUS, 8'h00, "status cleared");
        $display("test receive overrun done");

        {w0, w1, w2, m0, m1} = {8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
            8'($random(seed)), 8'($random(seed))};
        setup(4'h6, 1'h1, 1'h1);
        wr(`SSCS_OFF_CTRL, 8'h00);
        rd_chk(`SSCS_OFF_CTRL, 8'h16, "ctrl locked while running");
        rd_chk(`SSCS_OFF_RUN, 8'h01, "run started");
        wr(`SSCS_OFF_DATA, w0);
        wait_irq();
        wr(`SSCS_OFF_DATA, w1);
        fork
            frame(m0, w0, 4'h6);
            begin
                repeat (60) @(posedge clk);
                rd_chk(`SSCS_OFF_DATA, w1, "tx word mid shift");
                wr(`SSCS_OFF_DATA, w2);
                rd_chk(`SSCS_OFF_STATUS, 8'h06, "status mid shift");
            end
        join
        wait_irq();
        rd_chk(`SSCS_OFF_DATA, exp_rx.pop_front(), "rx word cont");
        wr(`SSCS_OFF_MODE, 8'h00);
        frame(m1, w2, 4'h6);
        wait_irq();
        rd_chk(`SSCS_OFF_DATA, exp_rx.pop_front(), "last rx word");
        wr(`SSCS_OFF_MODE, 8'h01);
        $display("test continuous done");

        wr(`SSCS_OFF_RUN, 8'h02);
        frame(8'h3c, 8'hff, 4'h6);
        exp_rx.delete();
        repeat (20) @(posedge clk);
        chk("irq after stop", irq_exp[7:0], irq_cnt[7:0]);
        rd_chk(`SSCS_OFF_RUN, 8'h00, "run stopped");
        $display("test stop done");
        test_done();
    end
endmodule : sscs_slave_bench
